// ==== edge_unit_pkg.sv ====
// constants of the edge timing control block: offsets, field positions,
// reset values and masks; assumes a 32-bit apb data path
package edge_unit_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;

  // ----------------------------------------------------------------
  // byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTL = 12'h000; // control word
  localparam logic [11:0] OFF_CLR = 12'h004; // clear alias
  localparam logic [11:0] OFF_SET = 12'h008; // set alias
  localparam logic [11:0] OFF_INV = 12'h00C; // invert alias
  localparam logic [11:0] OFF_IST = 12'h010; // interrupt status, write one to clear
  localparam logic [11:0] OFF_IMSK = 12'h014; // interrupt mask

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int BIT_E1_STYLE = 31;
  localparam int BIT_E1_POL = 30;
  localparam int SEL1_HI = 29;
  localparam int SEL1_LO = 26;
  localparam int BIT_E2_STAT = 25;
  localparam int BIT_E1_STAT = 24;
  localparam int BIT_E2_STYLE = 23;
  localparam int BIT_E2_POL = 22;
  localparam int SEL2_HI = 21;
  localparam int SEL2_LO = 18;
  localparam int BIT_ON = 15;
  localparam int BIT_IDLE = 13;
  localparam int BIT_DLY = 12;
  localparam int BIT_PASS = 11;
  localparam int BIT_SEQ = 10;
  localparam int BIT_SINK = 9;
  localparam int BIT_TRIG = 8;
  localparam int TRIM_HI = 7;
  localparam int TRIM_LO = 2;
  localparam int RNG_HI = 1;
  localparam int RNG_LO = 0;

  // implemented bits: 17,16 and 14 stay zero
  localparam logic [31:0] CTL_IMPL_MASK = 32'hFFFCBFFF;
  localparam logic [31:0] CTL_STAT_MASK = 32'h03000000;
  localparam logic [31:0] CTL_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // interrupt status layout
  // ----------------------------------------------------------------
  localparam int IRQ_E1 = 0;
  localparam int IRQ_E2 = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // number of selectable sources per edge input
  localparam int NUM_SRC = 16;

endpackage : edge_unit_pkg

// ==== edge_chan_if.sv ====
// one edge input channel between the control block and its detector;
// assumes both ends share the block clock
`timescale 1ns/1ps
`default_nettype none
interface edge_chan_if;
  logic [15:0] sources; // candidate source levels, index = select code
  logic [3:0] select; // source select code
  logic polarity; // 1 rising/high, 0 falling/low
  logic sense_style; // 1 edge, 0 level
  logic pass; // edges let through
  logic hit; // qualified event this cycle
  modport ctl (output sources, select, polarity, sense_style, pass, input hit);
  modport det (input sources, select, polarity, sense_style, pass, output hit);
endinterface : edge_chan_if
`default_nettype wire

// ==== edge_detect.sv ====
// source selector and edge/level sensing for one edge input;
// assumes synchronous source levels and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module edge_detect
  import edge_unit_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  edge_chan_if.det ch
);

  // ----------------------------------------------------------------
  // selection and sensing
  // ----------------------------------------------------------------
  logic level; // chosen source
  logic prev_q; // chosen source one cycle ago
  logic rise;
  logic fall;
  logic raw;

  assign level = ch.sources[ch.select];
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
  // a change of select can look like an edge once; software should
  // program the selector before enabling edges
  assign raw = ch.sense_style ? (ch.polarity ? rise : fall)
                              : (level == ch.polarity);
  assign ch.hit = ch.pass & raw;

  // history of the chosen source
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rise_sense_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ch.hit && ch.sense_style && ch.polarity) |-> (!$past(level) && level))
    else $error("rising edge hit without a rise");
  level_sense_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ch.pass && !ch.sense_style && (level == ch.polarity)) |-> ch.hit)
    else $error("level match not reported");

endmodule : edge_detect
`default_nettype wire

// ==== edge_unit_control.sv ====
// control register bank of the edge timing unit with apb access,
// clear/set/invert aliases, edge status capture and an interrupt;
// assumes one 125 MHz clock and synchronous source inputs
//
// Notes on behaviour
// - clear, set, invert aliases at +4,+8,+C
// - unimplemented bits read zero, ignore writes
// - bit 31: edge1 edge or level sensing
// - bit 30: edge1 rising or falling polarity
// - bits 29..26 select edge1 source
// - codes F..D comparators, C..A captures
// - codes 9..4 pins 8..3, 3 pin1, 2 pin2
// - code 1 routes compare unit 1
// - code 0 routes timer1 event
// - upper half edge2 fields and statuses
// - lower half enable, trim, range fields
// - edge1 status set on edge, writable
// - edge enable zero blocks all edges
// - module enable turns unit on/off
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module edge_unit_control
  import edge_unit_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [edge_unit_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [edge_unit_pkg::APB_DATA_W-1:0] pwdata,
  output logic [edge_unit_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // edge sources and idle mode input
  input wire logic [2:0] comparator_outputs,
  input wire logic [2:0] capture_events,
  input wire logic [7:0] edge_pins,
  input wire logic compare1_event,
  input wire logic timer1_event,
  input wire logic [15:0] edge2_sources,
  input wire logic idle_mode,
  // configuration and status outputs
  output logic module_enable,
  output logic unit_active,
  output logic idle_stop,
  output logic delay_generation_enable,
  output logic current_sink_ground,
  output logic trigger_output_enable,
  output logic [5:0] current_trim,
  output logic [1:0] current_range,
  output logic edge1_occurred,
  output logic edge2_occurred,
  output logic irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q; // first stage, read only by the second
  logic rst_n; // released reset used by the whole block

  // asserts at once, releases after two edges
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] ctl_q; // control word
  logic [31:0] ctl_d;
  logic [1:0] ist_q; // sticky interrupt status
  logic [1:0] ist_d;
  logic [1:0] imsk_q; // interrupt mask
  logic [31:0] rdata_q; // read data held through access phase

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic sel_ctl = (paddr == OFF_CTL);
  wire logic sel_clr = (paddr == OFF_CLR);
  wire logic sel_set = (paddr == OFF_SET);
  wire logic sel_inv = (paddr == OFF_INV);
  wire logic sel_ist = (paddr == OFF_IST);
  wire logic sel_imsk = (paddr == OFF_IMSK);
  wire logic sel_any_ctl = sel_ctl | sel_clr | sel_set | sel_inv;
  wire logic mapped = sel_any_ctl | sel_ist | sel_imsk;
  wire logic setup_rd = psel & ~penable & ~pwrite;
  wire logic access = psel & penable;
  wire logic wr_en = access & pwrite & mapped;
  wire logic wr_ctl = wr_en & sel_any_ctl;

  // zero wait state: every access phase completes at once
  assign pready = access;
  // unmapped addresses complete with an error and change nothing
  assign pslverr = access & ~mapped;
  assign prdata = rdata_q;

  // ----------------------------------------------------------------
  // software view of the next control word
  // ----------------------------------------------------------------
  logic [31:0] alias_val; // value produced by the addressed alias
  logic [31:0] ctl_sw; // control word after software only

  // plain write replaces; aliases act only on one bits
  assign alias_val = sel_clr ? (ctl_q & ~pwdata) :
                     sel_set ? (ctl_q | pwdata) :
                     sel_inv ? (ctl_q ^ pwdata) : pwdata;
  // unimplemented positions never store anything
  assign ctl_sw = wr_ctl ? (alias_val & CTL_IMPL_MASK) : ctl_q;

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire logic e1_style = ctl_q[BIT_E1_STYLE];
  wire logic e1_pol = ctl_q[BIT_E1_POL];
  wire logic [3:0] e1_sel = ctl_q[SEL1_HI:SEL1_LO];
  wire logic e2_style = ctl_q[BIT_E2_STYLE];
  wire logic e2_pol = ctl_q[BIT_E2_POL];
  wire logic [3:0] e2_sel = ctl_q[SEL2_HI:SEL2_LO];
  wire logic pass_en = ctl_q[BIT_PASS];
  wire logic seq_en = ctl_q[BIT_SEQ];

  // unit runs when on and not parked by idle
  wire logic active = ctl_q[BIT_ON] & ~(ctl_q[BIT_IDLE] & idle_mode);

  // ----------------------------------------------------------------
  // edge source vectors, index is the select code
  // ----------------------------------------------------------------
  logic [15:0] e1_sources;
  assign e1_sources = {comparator_outputs[2], comparator_outputs[1],
                       comparator_outputs[0],
                       capture_events[2], capture_events[1], capture_events[0],
                       edge_pins[7:2],
                       edge_pins[0], edge_pins[1],
                       compare1_event,
                       timer1_event};

  // ----------------------------------------------------------------
  // detectors
  // ----------------------------------------------------------------
  logic [1:0] hit; // per channel qualified event
  logic [1:0][15:0] ch_src;
  logic [1:0][3:0] ch_sel;
  logic [1:0] ch_pol;
  logic [1:0] ch_style;

  assign ch_src[0] = e1_sources;
  assign ch_src[1] = edge2_sources;
  assign ch_sel[0] = e1_sel;
  assign ch_sel[1] = e2_sel;
  assign ch_pol[0] = e1_pol;
  assign ch_pol[1] = e2_pol;
  assign ch_style[0] = e1_style;
  assign ch_style[1] = e2_style;

  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    edge_chan_if chan ();
    assign chan.sources = ch_src[i];
    assign chan.select = ch_sel[i];
    assign chan.polarity = ch_pol[i];
    assign chan.sense_style = ch_style[i];
    assign chan.pass = pass_en;
    assign hit[i] = chan.hit;
    edge_detect u_det (
      .clk(ref_clk),
      .rst_n(rst_n),
      .ch(chan)
    );
  end

  // ----------------------------------------------------------------
  // hardware status setting
  // ----------------------------------------------------------------
  logic set_e1;
  logic set_e2;

  assign set_e1 = active & hit[0];
  // with sequencing, edge2 counts only after edge1 was seen
  assign set_e2 = active & hit[1] & (~seq_en | ctl_q[BIT_E1_STAT]);

  // hardware set wins over a software clear in the same cycle
  assign ctl_d = ctl_sw | ({32{set_e1}} & (32'h1 << BIT_E1_STAT))
                        | ({32{set_e2}} & (32'h1 << BIT_E2_STAT));

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [1:0] ist_clr; // write-one-to-clear pattern
  logic [1:0] ev; // new events
  assign ist_clr = (wr_en & sel_ist) ? pwdata[1:0] : 2'h0;
  assign ev = {set_e2, set_e1};
  assign ist_d = (ist_q & ~ist_clr) | ev;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  assign rd_val = sel_any_ctl ? ctl_q :
                  sel_ist ? {30'h0, ist_q} :
                  sel_imsk ? {30'h0, imsk_q} : 32'h00000000;

  // control word storage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_q <= CTL_RESET;
    else
      ctl_q <= ctl_d;
  end

  // interrupt registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_q <= IRQ_RESET;
      imsk_q <= IRQ_RESET;
    end
    else
    begin
      ist_q <= ist_d;
      if (wr_en && sel_imsk)
        imsk_q <= pwdata[1:0];
    end
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h00000000;
    else if (setup_rd)
      rdata_q <= rd_val;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign module_enable = ctl_q[BIT_ON];
  assign unit_active = active;
  assign idle_stop = ctl_q[BIT_IDLE];
  assign delay_generation_enable = ctl_q[BIT_DLY];
  assign current_sink_ground = ctl_q[BIT_SINK];
  assign trigger_output_enable = ctl_q[BIT_TRIG];
  assign current_trim = ctl_q[TRIM_HI:TRIM_LO];
  assign current_range = ctl_q[RNG_HI:RNG_LO];
  assign edge1_occurred = ctl_q[BIT_E1_STAT];
  assign edge2_occurred = ctl_q[BIT_E2_STAT];
  // level output while any unmasked status bit stands
  assign irq = |(ist_q & imsk_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence ctl_write_s(logic [11:0] off);
    psel && penable && pwrite && (paddr == off);
  endsequence

  alias_clear_a: assert property (
    ctl_write_s(OFF_CLR) |=> ((ctl_q & ~CTL_STAT_MASK) ==
      ($past(ctl_q) & ~$past(pwdata) & ~CTL_STAT_MASK)))
    else $error("clear alias wrong");
  alias_set_a: assert property (
    ctl_write_s(OFF_SET) |=> ((ctl_q & ~CTL_STAT_MASK) ==
      (($past(ctl_q) | $past(pwdata)) & CTL_IMPL_MASK & ~CTL_STAT_MASK)))
    else $error("set alias wrong");
  alias_invert_a: assert property (
    ctl_write_s(OFF_INV) |=> ((ctl_q & ~CTL_STAT_MASK) ==
      (($past(ctl_q) ^ $past(pwdata)) & CTL_IMPL_MASK & ~CTL_STAT_MASK)))
    else $error("invert alias wrong");
  unimpl_zero_a: assert property (
    (ctl_q & ~CTL_IMPL_MASK) == 32'h00000000)
    else $error("unimplemented bit set");
  edge_block_a: assert property (
    (!pass_en && !wr_ctl) |=> (ctl_q[BIT_E1_STAT] == $past(ctl_q[BIT_E1_STAT])))
    else $error("edge passed while blocked");
  unit_off_a: assert property (
    (!ctl_q[BIT_ON] && !wr_ctl) |=> $stable(ctl_q[BIT_E2_STAT]))
    else $error("status changed while off");
  edge_seq_a: assert property (
    (seq_en && !ctl_q[BIT_E1_STAT] && !wr_ctl) |=> !$rose(ctl_q[BIT_E2_STAT]))
    else $error("edge2 before edge1");
  edge1_set_a: assert property (
    set_e1 |=> (edge1_occurred && ist_q[IRQ_E1]))
    else $error("edge1 event lost");

  // apb side: read data is taken at setup, so an access phase must
  // present exactly the word that stood one edge earlier
  sequence ctl_rd_setup_s;
    psel && !penable && !pwrite && sel_any_ctl;
  endsequence

  sequence apb_access_s;
    psel && penable;
  endsequence

  ctl_read_a: assert property (
    (ctl_rd_setup_s ##1 apb_access_s) |-> (prdata == $past(ctl_q)))
    else $error("control read data wrong");
  plain_write_a: assert property (
    ctl_write_s(OFF_CTL) |=> ((ctl_q & ~CTL_STAT_MASK) ==
      ($past(pwdata) & CTL_IMPL_MASK & ~CTL_STAT_MASK)))
    else $error("plain control write wrong");
  // a refused address must leave the word alone unless hardware sets a status
  unmapped_write_a: assert property (
    (psel && penable && pwrite && !mapped && !set_e1 && !set_e2) |=> $stable(ctl_q))
    else $error("unmapped write changed control");

  // edge side: parking in idle blocks captures like the enable bits do
  idle_block_a: assert property (
    (idle_mode && ctl_q[BIT_IDLE] && !wr_ctl) |=> $stable(ctl_q[BIT_E1_STAT]))
    else $error("edge taken while parked in idle");
  edge2_set_a: assert property (
    set_e2 |=> (edge2_occurred && ist_q[IRQ_E2]))
    else $error("edge2 event lost");

  // interrupt registers: mask is a plain store, status clears only on ones
  mask_write_a: assert property (
    (wr_en && sel_imsk) |=> (imsk_q == $past(pwdata[1:0])))
    else $error("mask write lost");
  status_clear_a: assert property (
    (wr_en && sel_ist && !set_e1 && !set_e2) |=>
      (ist_q == ($past(ist_q) & ~$past(pwdata[1:0]))))
    else $error("status clear wrong");

endmodule : edge_unit_control
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the edge timing control block: apb master,
// register model with aliases, edge source stimulus and interrupt checks
// assumes zero-wait apb and status capture one edge after a qualified hit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import edge_unit_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] src = 16'h0000; // edge1 sources, index = select code
  logic [15:0] e2src = 16'h0000; // edge2 sources, index = select code
  logic idle_mode = 1'b0;
  logic [2:0] cmp_w;
  logic [2:0] cap_w;
  logic [7:0] pin_w;
  logic module_enable, unit_active, idle_stop, delay_generation_enable;
  logic current_sink_ground, trigger_output_enable, edge1_occurred, edge2_occurred, irq;
  logic [5:0] current_trim;
  logic [1:0] current_range;
  logic [31:0] ctl_m = 32'h00000000; // model of the control word
  logic [1:0] ist_m = 2'h0; // model of interrupt status
  logic [1:0] imsk_m = 2'h0; // model of interrupt mask
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  integer seed = 32'he8a9;
  logic [31:0] base_w = 32'hC0C08800; // on, pass, both inputs rising edge
  logic [31:0] r_w;
  logic e_w;
  logic [11:0] off_w;
  // select code to source wiring, straight from the edge1 source table
  assign cmp_w = src[15:13];
  assign cap_w = src[12:10];
  assign pin_w = {src[9:4], src[2], src[3]};
  always #4 ref_clk = ~ref_clk;
  edge_unit_control uut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_outputs(cmp_w), .capture_events(cap_w),
    .edge_pins(pin_w), .compare1_event(src[1]), .timer1_event(src[0]),
    .edge2_sources(e2src), .idle_mode(idle_mode), .module_enable(module_enable),
    .unit_active(unit_active), .idle_stop(idle_stop),
    .delay_generation_enable(delay_generation_enable),
    .current_sink_ground(current_sink_ground), .trigger_output_enable(trigger_output_enable),
    .current_trim(current_trim), .current_range(current_range),
    .edge1_occurred(edge1_occurred), .edge2_occurred(edge2_occurred), .irq(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask : chk
  // one apb transfer; entered right after an edge, so one idle cycle between
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // no wait limit of its own: only the bench timeout ends a stuck transfer
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // outputs follow the model word; irq is the masked status or
  task automatic chk_outs();
    chk({18'h0, module_enable, unit_active, idle_stop, delay_generation_enable,
      current_sink_ground, trigger_output_enable, current_trim, current_range},
      {18'h0, ctl_m[15], ctl_m[15] & ~(ctl_m[13] & idle_mode), ctl_m[13], ctl_m[12],
      ctl_m[9], ctl_m[8], ctl_m[7:2], ctl_m[1:0]}, "config outputs");
    chk({29'h0, edge2_occurred, edge1_occurred, irq},
      {29'h0, ctl_m[25], ctl_m[24], |(ist_m & imsk_m)}, "status outputs");
  endtask : chk_outs
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, 32'h00000000, "read error");
  endtask : rd_chk
  task automatic ctl_chk();
    rd_chk(OFF_CTL, ctl_m);
    rd_chk(OFF_IST, {30'h0, ist_m});
    chk_outs();
  endtask : ctl_chk
  // write with the model kept in step; aliases touch only the one bits
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h00000000, "write error");
    case (a)
      OFF_CTL: ctl_m = d & CTL_IMPL_MASK;
      OFF_CLR: ctl_m = ctl_m & ~d;
      OFF_SET: ctl_m = ctl_m | (d & CTL_IMPL_MASK);
      OFF_INV: ctl_m = ctl_m ^ (d & CTL_IMPL_MASK);
      OFF_IST: ist_m = ist_m & ~d[1:0];
      OFF_IMSK: imsk_m = d[1:0];
      default: ;
    endcase
    // the write lands at the access edge; let it settle before any compare
    @(posedge ref_clk);
  endtask : wr
  // move one source line, let it settle, then compare all outputs
  task automatic drive(input int code, input logic second, input logic val, input logic hit);
    @(posedge ref_clk);
    if (second)
      e2src[code] <= val;
    else
      src[code] <= val;
    repeat (3) @(posedge ref_clk);
    if (hit)
    begin
      ctl_m[BIT_E1_STAT + int'(second)] = 1'b1;
      ist_m[second] = 1'b1;
    end
    chk_outs();
  endtask : drive
  // ----------------------------------------------------------------
  // timeout and main sequence
  // ----------------------------------------------------------------
  // the whole run needs under a thousand cycles; a hang stops at the ceiling
  always @(posedge ref_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      $display("[FAIL] %0t timeout", $time);
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ctl_chk();
    rd_chk(OFF_IMSK, 32'h00000000);
    wr(OFF_CTL, 32'hFFFFFFFF);
    ctl_chk();
    wr(OFF_CTL, 32'h00000000);
    // random alias traffic with the unit held off, read back at each alias
    for (int i = 0; i < 12; i++)
    begin
      off_w = {8'h00, 2'(unsigned'($random(seed))), 2'b00};
      wr(off_w, $random(seed) & ~32'h00008800);
      rd_chk(off_w, ctl_m);
    end
    apb(1'b0, 12'h018, 32'h00000000, r_w, e_w);
    chk(r_w, 32'h00000000, "unmapped read data");
    chk({31'h0, e_w}, 32'h00000001, "unmapped read error");
    apb(1'b1, 12'h018, 32'hFFFFFFFF, r_w, e_w);
    chk({31'h0, e_w}, 32'h00000001, "unmapped write");
    ctl_chk();
    wr(OFF_CTL, 32'h00000000);
    // every edge1 code: a neighbour source must not hit, the chosen one must
    for (int c = 0; c < 16; c++)
    begin
      wr(OFF_CTL, base_w | (c << 26));
      drive((c + 1) % 16, 1'b0, 1'b1, 1'b0);
      drive((c + 1) % 16, 1'b0, 1'b0, 1'b0);
      drive(c, 1'b0, 1'b1, 1'b1);
      drive(c, 1'b0, 1'b0, 1'b0);
      ctl_chk();
      wr(OFF_CLR, 32'h01000000);
      wr(OFF_IST, 32'h00000001);
    end
    // falling polarity: rise ignored, fall hits
    wr(OFF_CTL, (base_w & ~32'h40000000) | (5 << 26));
    drive(5, 1'b0, 1'b1, 1'b0);
    drive(5, 1'b0, 1'b0, 1'b1);
    wr(OFF_CLR, 32'h01000000);
    // level sensing keeps hitting, so a clear does not stick while high
    wr(OFF_CTL, (base_w & ~32'h80000000) | (5 << 26));
    drive(5, 1'b0, 1'b1, 1'b1);
    wr(OFF_CLR, 32'h01000000);
    ctl_m[24] = 1'b1;
    ctl_chk();
    drive(5, 1'b0, 1'b0, 1'b0);
    wr(OFF_CLR, 32'h01000000);
    // edge sensing: a held high level does not re-set a cleared status
    wr(OFF_CTL, base_w | (5 << 26));
    drive(5, 1'b0, 1'b1, 1'b1);
    wr(OFF_CLR, 32'h01000000);
    ctl_chk();
    drive(5, 1'b0, 1'b0, 1'b0);
    // interrupt masked, unmasked, cleared
    wr(OFF_IMSK, 32'h00000001);
    chk_outs();
    rd_chk(OFF_IMSK, 32'h00000001);
    wr(OFF_IST, 32'h00000001);
    chk_outs();
    // pass off, module off, idle stop in idle: all block the edge
    for (int i = 0; i < 3; i++)
    begin
      idle_mode <= (i == 2);
      wr(OFF_CTL, (i == 0) ? ((base_w & ~32'h00000800) | (5 << 26)) :
        (i == 1) ? ((base_w & ~32'h00008000) | (5 << 26)) : (base_w | 32'h2000 | (5 << 26)));
      drive(5, 1'b0, 1'b1, 1'b0);
      drive(5, 1'b0, 1'b0, 1'b0);
    end
    idle_mode <= 1'b0;
    // sequencing: edge2 ignored until edge1 has occurred
    wr(OFF_IMSK, 32'h00000003);
    wr(OFF_CTL, base_w | 32'h00000400 | (7 << 26) | (3 << 18));
    drive(3, 1'b1, 1'b1, 1'b0);
    drive(3, 1'b1, 1'b0, 1'b0);
    drive(7, 1'b0, 1'b1, 1'b1);
    drive(7, 1'b0, 1'b0, 1'b0);
    drive(3, 1'b1, 1'b1, 1'b1);
    drive(3, 1'b1, 1'b0, 1'b0);
    ctl_chk();
    // a second reset in mid-run returns everything to zero
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    ctl_m = 32'h00000000;
    ist_m = 2'h0;
    imsk_m = 2'h0;
    repeat (3) @(posedge ref_clk);
    ctl_chk();
    rd_chk(OFF_IMSK, 32'h00000000);
    end_sim();
  end
endmodule : tb
`default_nettype wire
